/* dv/sbp_host.sv */
`timescale 1ns/1ps
`default_nettype none
// host model: single-word AHB-Lite master issuing guard commands
module sbp_host (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             hung
);
  // idle bus at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    hung   = 1'b0;
  end

  // wait for an edge with hready high, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && !hung) begin
      if (n == 64) hung <= 1'b1;
      n++;
      @(posedge clk);
    end
  endtask

  // one transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    haddr  <= ~haddr; // released address does not keep its value
    hwdata <= w ? d : ~hwdata; // write data only when writing
    wait_rdy();
    q = hrdata;
  endtask

  // command word: code in low bits, volatile value in bit 4
  task automatic cmd(input logic [2:0] c, input logic v);
    logic [31:0] q;
    xfer(1'b1, sbp_pkg::CTRL_OFS, {27'h0, v, 1'b0, c}, q);
  endtask

  // block selected by its first byte, unused high bits zero
  task automatic set_blk(input logic [7:0] b);
    logic [31:0] q;
    xfer(1'b1, sbp_pkg::ADDR_OFS, {6'h0, b, 18'h0}, q);
  endtask

  // register read
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
endmodule // sbp_host
`default_nettype wire

/* dv/sbp_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sbp_top_tb;
  logic        ref_clk;
  logic        nrst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        busy;
  logic        blk_prot;
  logic        hung;
  logic [31:0] q;
  int          n_errors = 0;
  int          cmp_count = 0;

  sbp_top #(.PROG_CYC(10), .ERASE_CYC(20)) sbp_top_i (
    .REF_CLK(ref_clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .BUSY(busy),
    .BLK_PROTECTED(blk_prot)
  );
  sbp_host sbp_host_i (
    .clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung)
  );

  // clock at 4 ns
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // counts, verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // a hung bus ends the run
  always @(posedge hung) begin
    n_errors++;
    complete_run();
  end

  // busy must rise, then fall, within bounds
  task automatic wait_op(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin @(posedge ref_clk); n++; end
    `CHK(busy, 1'b1)
    n = 0;
    while (busy !== 1'b0 && n < lim) begin @(posedge ref_clk); n++; end
    if (n == lim) begin n_errors++; complete_run(); end
  endtask

  // protection seen through register and pin
  task automatic chk_prot(input logic e);
    repeat (3) @(posedge ref_clk); // protection lags the guard bits by two edges
    sbp_host_i.rd(sbp_pkg::PROTECT_OFS, q);
    `CHK(q[0], e)
    repeat (4) @(posedge ref_clk);
    `CHK(blk_prot, e)
  endtask

  // read back the persistent bit of block b
  task automatic chk_pg(input logic [7:0] b, input logic e);
    sbp_host_i.set_blk(b);
    sbp_host_i.cmd(sbp_pkg::CMD_READ_PG, 1'b0);
    repeat (6) @(posedge ref_clk);
    sbp_host_i.rd(sbp_pkg::RDATA_OFS, q);
    `CHK(q[0], e)
  endtask

  // reset state: lock open, idle, nothing protected
  task automatic t_reset;
    sbp_host_i.rd(sbp_pkg::STATUS_OFS, q);
    `CHK(q[3:0], 4'h2)
    `CHK(hresp, 1'b0)
    sbp_host_i.set_blk(8'h00);
    chk_prot(1'b0);
    chk_pg(8'hff, 1'b1);
  endtask

  // volatile bit toggled repeatedly
  task automatic t_volatile;
    sbp_host_i.set_blk(8'h09);
    for (int i = 0; i < 4; i++) begin
      sbp_host_i.cmd(sbp_pkg::CMD_WRITE_VG, i[0]);
      chk_prot(~i[0]);
    end
  endtask

  // program one persistent bit, probe array read meanwhile
  task automatic t_prog(input logic [7:0] b);
    sbp_host_i.set_blk(b);
    sbp_host_i.cmd(sbp_pkg::CMD_PROG_PG, 1'b0);
    sbp_host_i.cmd(sbp_pkg::CMD_READ_ARR, 1'b0);
    sbp_host_i.rd(sbp_pkg::STATUS_OFS, q);
    `CHK({q[3], q[0]}, 2'h3)
    `CHK(busy, 1'b1)
    wait_op(300);
    chk_pg(b, 1'b0);
    chk_pg(b + 8'h01, 1'b1);
    sbp_host_i.cmd(sbp_pkg::CMD_WRITE_VG, 1'b1);
    sbp_host_i.set_blk(b);
    chk_prot(1'b1);
  endtask

  // erase with an unrelated address restores every bit
  task automatic t_erase;
    sbp_host_i.set_blk(8'hc8);
    sbp_host_i.cmd(sbp_pkg::CMD_ERASE_PG, 1'b0);
    wait_op(600);
    chk_pg(8'h05, 1'b1);
    chk_prot(1'b0);
  endtask

  // reset drops volatile state, keeps persistent
  task automatic t_reset_keep;
    t_prog(8'h05);
    sbp_host_i.set_blk(8'h07);
    sbp_host_i.cmd(sbp_pkg::CMD_WRITE_VG, 1'b0);
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    sbp_host_i.set_blk(8'h07);
    chk_prot(1'b0);
    chk_pg(8'h05, 1'b0);
  endtask

  // cleared lock refuses erase and program
  task automatic t_lock;
    sbp_host_i.cmd(sbp_pkg::CMD_LOCK, 1'b0);
    sbp_host_i.cmd(sbp_pkg::CMD_ERASE_PG, 1'b0);
    repeat (30) @(posedge ref_clk);
    sbp_host_i.rd(sbp_pkg::STATUS_OFS, q);
    `CHK(q[2:0], 3'h4)
    sbp_host_i.set_blk(8'h06);
    sbp_host_i.cmd(sbp_pkg::CMD_PROG_PG, 1'b0);
    repeat (30) @(posedge ref_clk);
    chk_pg(8'h06, 1'b1);
    chk_pg(8'h05, 1'b0);
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_volatile();
    t_prog(8'h05);
    t_erase();
    t_reset_keep();
    t_lock();
    complete_run();
  end
endmodule // sbp_top_tb
`undef CHK
`default_nettype wire

/* hw/sbp_guard_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// guard bit store with a registered read port and whole-array fill
module sbp_guard_mem #(
  parameter int   DEPTH  = 256,
  parameter int   AW     = 8,
  parameter logic INIT   = 1'b1
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic          wdata,
  input  wire logic          fill,
  input  wire logic [AW-1:0] raddr,
  output logic               rdata
);
  logic [DEPTH-1:0] bits = {DEPTH{INIT}}; // power-up contents, kept when rst_n is tied off
  logic [DEPTH-1:0] next_bits;

  initial begin
    if (DEPTH != (1 << AW)) $error("depth must match address width");
  end

  // next contents: fill beats single write, both take wdata
  always_comb begin
    next_bits = bits;
    if (fill) begin
      next_bits = {DEPTH{wdata}};
    end else if (we) begin
      next_bits[waddr] = wdata;
    end
  end

  // store and registered read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bits <= {DEPTH{INIT}};
    end else begin
      bits <= next_bits;
    end
    rdata <= bits[raddr];
  end
endmodule // sbp_guard_mem
`default_nettype wire

/* hw/sbp_pkg.sv */
`default_nettype none
package sbp_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] ADDR_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] RDATA_OFS   = 8'h0c;
  localparam logic [7:0] PROTECT_OFS = 8'h10;
  // command codes written to the control register
  localparam logic [2:0] CMD_NONE     = 3'h0;
  localparam logic [2:0] CMD_PROG_PG  = 3'h1;
  localparam logic [2:0] CMD_ERASE_PG = 3'h2;
  localparam logic [2:0] CMD_READ_PG  = 3'h3;
  localparam logic [2:0] CMD_WRITE_VG = 3'h4;
  localparam logic [2:0] CMD_LOCK     = 3'h5;
  localparam logic [2:0] CMD_READ_ARR = 3'h6;
  // field positions
  localparam int CMD_LSB    = 0;
  localparam int VGVAL_BIT  = 4;
  localparam int BUSY_BIT   = 0;
  localparam int LOCK_BIT   = 1;
  localparam int FAIL_BIT   = 2;
  localparam int ARREJ_BIT  = 3;
  localparam int BLK_LSB    = 18;
  // memory geometry: 256KB blocks, 4KB sectors, 64 sectors per block
  localparam int BLOCKS     = 256;
  localparam int BLK_W      = 8;
  localparam int ADDR_W     = 26;
  // reset values
  localparam logic PG_ERASED   = 1'b1;
  localparam logic VG_RESET    = 1'b1;
  localparam logic LOCK_RESET  = 1'b1;
  // timing in microseconds and cycles at 250 MHz
  localparam int CLK_MHZ       = 250;
  localparam int PROG_TIME_US  = 200;
  localparam int ERASE_TIME_US = 1000;
  localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
  localparam int READ_LATENCY  = 2;
  // engine states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_PRE   = 5'b00010,
    ST_ERASE = 5'b00100,
    ST_PROG  = 5'b01000,
    ST_READ  = 5'b10000
  } sbp_state_type;
endpackage
`default_nettype wire

/* hw/sbp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sbp_top #(
  parameter int PROG_CYC  = sbp_pkg::PROG_CYCLES,
  parameter int ERASE_CYC = sbp_pkg::ERASE_CYCLES
) (
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             BUSY,
  output logic             BLK_PROTECTED
);
  localparam int CW = 20;

  initial begin
    if (PROG_CYC < 1 || PROG_CYC >= (1 << CW)) $error("bad program count");
    if (ERASE_CYC < 2 || ERASE_CYC >= (1 << CW)) $error("bad erase count");
  end

  // bus phase capture
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic        next_dp_wr;
  logic [7:0]  next_dp_addr;
  // control state
  sbp_pkg::sbp_state_type state;
  sbp_pkg::sbp_state_type next_state;
  logic [CW-1:0]           cnt;
  logic [CW-1:0]           next_cnt;
  logic [sbp_pkg::ADDR_W-1:0] addr;
  logic [sbp_pkg::ADDR_W-1:0] next_addr;
  logic        lock;
  logic        next_lock;
  logic        fail;
  logic        next_fail;
  logic        arr_rej;
  logic        next_arr_rej;
  logic        rd_bit;
  logic        next_rd_bit;
  logic [31:0] next_hrdata;
  logic        next_busy;
  logic        next_prot;
  // memory strobes
  logic        pg_we;
  logic        pg_fill;
  logic        pg_wdata;
  logic        vg_we;
  logic        vg_wdata;
  logic        pg_q;
  logic        vg_q;
  logic        cmd_wr;
  logic [2:0]  cmd;
  logic [sbp_pkg::BLK_W-1:0] blk;

  // block index from a byte address
  function automatic logic [sbp_pkg::BLK_W-1:0] blk_of(input logic [sbp_pkg::ADDR_W-1:0] a);
    return a[sbp_pkg::BLK_LSB +: sbp_pkg::BLK_W];
  endfunction

  assign blk    = blk_of(addr);
  assign cmd_wr = dp_wr && (dp_addr == sbp_pkg::CTRL_OFS);
  assign cmd    = HWDATA[sbp_pkg::CMD_LSB +: 3];

  // persistent bits; no reset reaches them, not even the device reset NRST
  sbp_guard_mem #(.DEPTH(sbp_pkg::BLOCKS), .AW(sbp_pkg::BLK_W), .INIT(sbp_pkg::PG_ERASED)) u_pg (
    .clk      (REF_CLK),
    .rst_n    (1'b1),
    .we       (pg_we),
    .waddr    (blk),
    .wdata    (pg_wdata),
    .fill     (pg_fill),
    .raddr    (blk),
    .rdata    (pg_q)
  );

  // volatile bits cleared to unprotected on reset
  sbp_guard_mem #(.DEPTH(sbp_pkg::BLOCKS), .AW(sbp_pkg::BLK_W), .INIT(sbp_pkg::VG_RESET)) u_vg (
    .clk      (REF_CLK),
    .rst_n    (NRST),
    .we       (vg_we),
    .waddr    (blk),
    .wdata    (vg_wdata),
    .fill     (1'b0),
    .raddr    (blk),
    .rdata    (vg_q)
  );

  // ahb address phase capture
  always_comb begin
    next_dp_wr   = 1'b0;
    next_dp_addr = dp_addr;
    if (HSEL && HREADY && HTRANS[1] && HSIZE == 3'h2) begin
      next_dp_wr   = HWRITE;
      next_dp_addr = HADDR[7:0];
    end
  end

  // command engine
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_addr      = addr;
    next_lock      = lock;
    next_fail      = fail;
    next_arr_rej   = arr_rej;
    next_rd_bit    = rd_bit;
    pg_we          = 1'b0;
    pg_fill        = 1'b0;
    pg_wdata       = 1'b0;
    vg_we          = 1'b0;
    vg_wdata       = HWDATA[sbp_pkg::VGVAL_BIT];
    if (dp_wr && dp_addr == sbp_pkg::ADDR_OFS) begin
      next_addr = HWDATA[sbp_pkg::ADDR_W-1:0];
    end
    case (state)
      sbp_pkg::ST_IDLE: begin
        if (cmd_wr) begin
          next_fail = 1'b0;
          case (cmd)
            sbp_pkg::CMD_PROG_PG: begin
              if (!lock) next_fail = 1'b1;
              else begin
                next_state = sbp_pkg::ST_PROG;
                next_cnt   = CW'(PROG_CYC - 1);
              end
            end
            sbp_pkg::CMD_ERASE_PG: begin
              if (!lock) next_fail = 1'b1;
              else begin
                next_state = sbp_pkg::ST_PRE;
                next_cnt   = CW'(ERASE_CYC / 2 - 1);
              end
            end
            sbp_pkg::CMD_READ_PG: begin
              next_state = sbp_pkg::ST_READ;
              next_cnt   = CW'(sbp_pkg::READ_LATENCY - 1);
            end
            sbp_pkg::CMD_WRITE_VG: vg_we = 1'b1;
            sbp_pkg::CMD_LOCK:     next_lock = 1'b0;
            sbp_pkg::CMD_READ_ARR: next_arr_rej = 1'b0;
            default: ;
          endcase
        end
      end
      sbp_pkg::ST_PRE: begin
        pg_fill     = (cnt == '0);
        next_cnt    = cnt - CW'(1);
        if (cnt == '0) begin
          next_state = sbp_pkg::ST_ERASE;
          next_cnt   = CW'(ERASE_CYC - ERASE_CYC / 2 - 1);
        end
      end
      sbp_pkg::ST_ERASE: begin
        next_cnt = cnt - CW'(1);
        if (cnt == '0) begin
          pg_fill    = 1'b1;
          pg_wdata   = 1'b1;
          next_state = sbp_pkg::ST_IDLE;
        end
      end
      sbp_pkg::ST_PROG: begin
        if (cmd_wr && cmd == sbp_pkg::CMD_READ_ARR) next_arr_rej = 1'b1;
        next_cnt = cnt - CW'(1);
        if (cnt == '0) begin
          pg_we      = 1'b1;
          next_state = sbp_pkg::ST_IDLE;
        end
      end
      sbp_pkg::ST_READ: begin
        next_cnt = cnt - CW'(1);
        if (cnt == '0) begin
          next_rd_bit = pg_q;
          next_state  = sbp_pkg::ST_IDLE;
        end
      end
      default: next_state = sbp_pkg::ST_IDLE;
    endcase
  end

  // status and read data
  always_comb begin
    next_busy = (next_state == sbp_pkg::ST_PROG) || (next_state == sbp_pkg::ST_PRE)
             || (next_state == sbp_pkg::ST_ERASE);
    next_prot = !(pg_q && vg_q);
    next_hrdata = 32'h0000_0000;
    if (HSEL && HREADY && HTRANS[1] && HSIZE == 3'h2 && !HWRITE) begin
      if (HADDR[7:0] == sbp_pkg::ADDR_OFS) begin
        next_hrdata = 32'(addr);
      end else if (HADDR[7:0] == sbp_pkg::STATUS_OFS) begin
        next_hrdata[sbp_pkg::BUSY_BIT]  = BUSY || (state != sbp_pkg::ST_IDLE);
        next_hrdata[sbp_pkg::LOCK_BIT]  = lock;
        next_hrdata[sbp_pkg::FAIL_BIT]  = fail;
        next_hrdata[sbp_pkg::ARREJ_BIT] = arr_rej;
      end else if (HADDR[7:0] == sbp_pkg::RDATA_OFS) begin
        next_hrdata[0] = rd_bit;
      end else if (HADDR[7:0] == sbp_pkg::PROTECT_OFS) begin
        next_hrdata[0] = BLK_PROTECTED;
      end else begin
        next_hrdata = 32'h0000_0000;
      end
    end
  end

  // registers
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      dp_wr         <= 1'b0;
      dp_addr       <= 8'h00;
      state         <= sbp_pkg::ST_IDLE;
      cnt           <= '0;
      addr          <= '0;
      lock          <= sbp_pkg::LOCK_RESET;
      fail          <= 1'b0;
      arr_rej       <= 1'b0;
      rd_bit        <= sbp_pkg::PG_ERASED;
      HRDATA        <= 32'h0000_0000;
      HREADYOUT     <= 1'b1;
      HRESP         <= 1'b0;
      BUSY          <= 1'b0;
      BLK_PROTECTED <= 1'b0;
    end else begin
      dp_wr         <= next_dp_wr;
      dp_addr       <= next_dp_addr;
      state         <= next_state;
      cnt           <= next_cnt;
      addr          <= next_addr;
      lock          <= next_lock;
      fail          <= next_fail;
      arr_rej       <= next_arr_rej;
      rd_bit        <= next_rd_bit;
      HRDATA        <= next_hrdata;
      HREADYOUT     <= 1'b1;
      HRESP         <= 1'b0;
      BUSY          <= next_busy;
      BLK_PROTECTED <= next_prot;
    end
  end

  // busy follows a persistent program start
  property p_prog_busy;
    @(posedge REF_CLK) disable iff (!NRST)
      (state == sbp_pkg::ST_IDLE && cmd_wr && cmd == sbp_pkg::CMD_PROG_PG && lock)
      |=> BUSY;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("busy missing after program");

  // locked program or erase never starts
  property p_lock_rej;
    @(posedge REF_CLK) disable iff (!NRST)
      (state == sbp_pkg::ST_IDLE && cmd_wr && !lock
       && (cmd == sbp_pkg::CMD_PROG_PG || cmd == sbp_pkg::CMD_ERASE_PG))
      |=> state == sbp_pkg::ST_IDLE && fail;
  endproperty
  a_lock_rej: assert property (p_lock_rej) else $error("locked command ran");

  // lock bit only ever falls
  property p_lock_mono;
    @(posedge REF_CLK) disable iff (!NRST) !$rose(lock);
  endproperty
  a_lock_mono: assert property (p_lock_mono) else $error("lock set by software");

  // persistent read completes within read latency
  property p_read_lat;
    @(posedge REF_CLK) disable iff (!NRST)
      (state == sbp_pkg::ST_READ && cnt == CW'(sbp_pkg::READ_LATENCY - 1))
      |-> ##[1:2] state == sbp_pkg::ST_IDLE;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("guard read too slow");

  // protected unless both guard bits are 1
  property p_prot_eq;
    @(posedge REF_CLK) disable iff (!NRST)
      ##1 BLK_PROTECTED == !($past(pg_q) && $past(vg_q));
  endproperty
  a_prot_eq: assert property (p_prot_eq) else $error("protection combine wrong");

  // array read during program is flagged
  property p_arr_rej;
    @(posedge REF_CLK) disable iff (!NRST)
      (state == sbp_pkg::ST_PROG && cmd_wr && cmd == sbp_pkg::CMD_READ_ARR) |=> arr_rej;
  endproperty
  a_arr_rej: assert property (p_arr_rej) else $error("array read not refused");

  // erase goes through preprogram then erase
  sequence s_pre_end;
    state == sbp_pkg::ST_PRE && cnt == '0;
  endsequence
  property p_erase_seq;
    @(posedge REF_CLK) disable iff (!NRST) s_pre_end |=> state == sbp_pkg::ST_ERASE;
  endproperty
  a_erase_seq: assert property (p_erase_seq) else $error("erase skipped step");

  // program writes exactly at the end of its count
  property p_prog_we;
    @(posedge REF_CLK) disable iff (!NRST)
      pg_we |-> state == sbp_pkg::ST_PROG && cnt == '0 && !pg_fill;
  endproperty
  a_prog_we: assert property (p_prog_we) else $error("stray persistent write");
endmodule // sbp_top
`default_nettype wire
